/* verilog/drs_sequencer.v */
// Functional notes
// [R1] Self test first, then restore valid copy.
// [R2] No valid copy: zero-fill array with good checks.
// [R3] Report E1 if stale, E0 if empty.
// [R4] Mains loss aborts restore, starts save; a loss during restore only returns to idle, and save needs a further loss.
// [R5] Mains return aborts save, restores if needed.
// [R6] Spin-down saves valid array with invalid copy.
// [R7] Spin-up aborts save, marks no data.
// [R8] Spin requests ignored until fully restored.
// [R9] Failure latches fault and raises attention.
// [R10] Fault reported three times per online event.
// [R11] Fault clears only by a successful powerup.
// [R12] Faulted retention still allows reads and writes.
// [R13] Self test lasts about thirty seconds.
// [R14] Restore takes 120 to 480 seconds.
// [R15] Self test covers memories, chips, arrays, buses.
// [R16] Valid only after a complete successful save.
// [R17] Valid becomes stale on write or online.
// [R18] Incomplete save sets status to no data.
// [R19] Events arrive as single-cycle synchronous pulses.
// [R20] Status register survives operations, set only here.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "drs_map.vh"

module drs_sequencer #(
    parameter CLK_HZ      = `DRS_CLK_HZ,
    parameter TEST_SEC    = `DRS_TEST_SEC,
    parameter RESTORE_MAX = `DRS_RESTORE_MAX_SEC,
    parameter REPORTS     = `DRS_FAULT_REPORTS
) (
    input  wire        i_mclk,
    input  wire        i_rst,
    input  wire        i_ac_loss,
    input  wire        i_ac_return,
    input  wire        i_spin_up,
    input  wire        i_spin_down,
    input  wire        i_lbn_write,
    input  wire        i_online_ok,
    input  wire [14:0] i_test_fail,
    input  wire        i_op_fail,
    input  wire        i_xfer_done,
    input  wire        i_xfer_fail,
    input  wire        i_attn_ack,
    input  wire [3:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    output wire        o_save_go,
    output wire        o_restore_go,
    output wire        o_zero_go,
    output wire        o_xfer_abort,
    output wire [1:0]  o_error_detect_bits,
    output wire        o_forced_error_flag,
    output reg  [7:0]  o_err_code,
    output reg         o_err_valid,
    output wire        o_attn,
    output wire        o_faulted,
    output wire        o_host_access_ok
);

    localparam [6:0] S_TEST    = 7'h01;
    localparam [6:0] S_RESTORE = 7'h02;
    localparam [6:0] S_ZERO    = 7'h04;
    localparam [6:0] S_IDLE    = 7'h08;
    localparam [6:0] S_SAVE    = 7'h10;
    localparam [6:0] S_ZFAIL   = 7'h20;
    localparam [6:0] S_SPARE   = 7'h40;

    wire       sec_tick;
    reg  [6:0] state_reg;
    reg  [6:0] state_next;
    reg  [1:0] status_reg;
    reg  [1:0] status_next;
    reg        restored_reg;
    reg        restored_next;
    reg        fault_reg;
    reg        online_reg;
    reg  [8:0] sec_reg;
    reg  [1:0] attn_cnt_reg;
    reg        attn_pend_reg;
    wire       fail_evt;
    wire       test_done;
    wire       restore_late;
    wire       rest_end;
    reg  [14:0] tfail_reg;
    reg  [3:0] cause_reg;
    reg  [7:0] abort_cnt_reg;
    reg  [1:0] outcome_reg;
    reg  [15:0] save_cnt_reg;
    genvar     gi;

    drs_tick #(
        .CLK_HZ (CLK_HZ)
    ) u_tick (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .o_sec  (sec_tick)
    );

    function is_state;
        input [6:0] cur;
        input [6:0] want;
        begin
            is_state = (cur == want);
        end
    endfunction

    assign test_done    = is_state(state_reg, S_TEST) && (sec_reg == TEST_SEC[8:0]); // [R13]
    assign restore_late = is_state(state_reg, S_RESTORE) && (sec_reg >= RESTORE_MAX[8:0]); // [R14]
    assign rest_end     = is_state(state_reg, S_RESTORE) && i_xfer_done;
    assign fail_evt     = (test_done && (i_test_fail != 15'h0)) || i_op_fail || // [R15]
                          (i_xfer_fail && !is_state(state_reg, S_IDLE)) || restore_late; // [R9]

    // Next state and retention status.
    always @*
    begin
        state_next    = state_reg;
        status_next   = status_reg;
        restored_next = restored_reg;
        case (state_reg)
            S_TEST:
            begin
                if (test_done)
                begin
                    if (status_reg == `DRS_ST_VALID)
                        state_next = S_RESTORE; // [R1]
                    else
                        state_next = S_ZERO; // [R2]
                end
            end
            S_RESTORE:
            begin
                if (i_ac_loss || i_xfer_fail || restore_late)
                    state_next = S_IDLE; // [R4]
                else if (i_xfer_done)
                begin
                    state_next    = S_IDLE;
                    restored_next = 1'b1;
                end
            end
            S_ZERO:
            begin
                if (i_xfer_done || i_xfer_fail)
                begin
                    state_next    = S_IDLE;
                    restored_next = 1'b1;
                end
            end
            S_SAVE:
            begin
                if (i_ac_return || (i_spin_up && restored_reg) || i_xfer_fail) // [R5] [R7] [R8]
                begin
                    state_next  = S_IDLE;
                    status_next = `DRS_ST_NODATA; // [R18]
                end
                else if (i_xfer_done)
                begin
                    state_next  = S_IDLE;
                    status_next = `DRS_ST_VALID; // [R16]
                end
            end
            S_IDLE:
            begin
                if (i_ac_loss)
                    state_next = S_SAVE; // [R4]
                else if (i_ac_return && !restored_reg && (status_reg == `DRS_ST_VALID))
                    state_next = S_RESTORE; // [R5]
                else if (i_spin_down && restored_reg && (status_reg != `DRS_ST_VALID))
                    state_next = S_SAVE; // [R6] [R8]
                else if ((i_lbn_write || i_online_ok) && (status_reg == `DRS_ST_VALID))
                    status_next = `DRS_ST_STALE; // [R17]
            end
            default:
                state_next = S_IDLE;
        endcase
    end

    // Sequencer registers; reset loads no data, and retention status is otherwise only moved by the transitions above.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg    <= S_TEST;
            status_reg   <= `DRS_ST_NODATA;
            restored_reg <= 1'b0;
            sec_reg      <= 9'h0;
            o_err_code   <= 8'h00;
            o_err_valid  <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            status_reg   <= status_next; // [R20]
            restored_reg <= restored_next;
            o_err_valid  <= 1'b0;
            if (state_next != state_reg)
                sec_reg <= 9'h0;
            else if (sec_tick && (sec_reg != 9'h1FF))
                sec_reg <= sec_reg + 9'h1;
            if (is_state(state_reg, S_ZERO) && (i_xfer_done || i_xfer_fail))
            begin
                o_err_valid <= 1'b1;
                if (status_reg == `DRS_ST_STALE)
                    o_err_code <= `DRS_ERR_STALE; // [R3]
                else
                    o_err_code <= `DRS_ERR_NODATA; // [R3]
            end
        end
    end

    // Latched fault; only reset (a fresh powerup) clears it.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            fault_reg <= 1'b0; // [R11]
        else if (fail_evt)
            fault_reg <= 1'b1; // [R9]
    end

    // Attention reporting, three acknowledged reports per online event while faulted or per first failure while online.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            online_reg    <= 1'b0;
            attn_cnt_reg  <= 2'h0;
            attn_pend_reg <= 1'b0;
        end
        else
        begin
            if (i_wr && (i_addr == `DRS_ADDR_CTRL))
                online_reg <= i_wdata[`DRS_CTRL_ONLINE_BIT];
            if ((fail_evt && !fault_reg && online_reg) ||
                (fault_reg && i_online_ok))
            begin
                attn_cnt_reg  <= REPORTS[1:0]; // [R10]
                attn_pend_reg <= 1'b1;
            end
            else if (attn_pend_reg && i_attn_ack)
            begin
                attn_cnt_reg  <= attn_cnt_reg - 2'h1;
                attn_pend_reg <= (attn_cnt_reg != 2'h1);
            end
        end
    end

    // Latched self-test failure bits, one flop per test item.
    generate
        for (gi = 0; gi < 15; gi = gi + 1)
        begin : g_tfail
            always @(posedge i_mclk or posedge i_rst)
            begin
                if (i_rst)
                    tfail_reg[gi] <= 1'b0;
                else if (test_done && i_test_fail[gi])
                    tfail_reg[gi] <= 1'b1; // [R15]
            end
        end
    endgenerate

    // Sticky fault cause bits, so the host can tell sources apart after the fact.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            cause_reg <= 4'h0;
        else
        begin
            if (test_done && (i_test_fail != 15'h0))
                cause_reg[0] <= 1'b1; // [R15]
            if (i_op_fail)
                cause_reg[1] <= 1'b1; // [R9]
            if (i_xfer_fail && !is_state(state_reg, S_IDLE))
                cause_reg[2] <= 1'b1; // [R9]
            if (restore_late)
                cause_reg[3] <= 1'b1; // [R14]
        end
    end

    // Count of aborted transfers; saturates rather than wrapping.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            abort_cnt_reg <= 8'h00;
        else if (o_xfer_abort && (abort_cnt_reg != 8'hFF))
            abort_cnt_reg <= abort_cnt_reg + 8'h01;
    end

    // Outcome of the last transfer: 1 done, 2 failed, 3 aborted.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            outcome_reg <= 2'h0;
        else if (o_xfer_abort)
            outcome_reg <= 2'h3;
        else if (i_xfer_fail && !is_state(state_reg, S_IDLE))
            outcome_reg <= 2'h2;
        else if (i_xfer_done && !is_state(state_reg, S_IDLE))
            outcome_reg <= 2'h1;
    end

    // Count of clocks in save whose next status is valid: one per completed save, but every clock of a save begun valid except its abort or failure clock; saturates.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            save_cnt_reg <= 16'h0000;
        else if (is_state(state_reg, S_SAVE) && (status_next == `DRS_ST_VALID) &&
                 (save_cnt_reg != 16'hFFFF))
            save_cnt_reg <= save_cnt_reg + 16'h0001; // [R16]
    end

    // Register read port.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 32'h0;
        else if (i_rd)
        begin
            case (i_addr)
                `DRS_ADDR_CTRL: o_rdata <= {31'h0, online_reg};
                `DRS_ADDR_STAT: o_rdata <= {24'h0, state_reg[2], state_reg[1],
                                            state_reg[4], fault_reg, restored_reg,
                                            !is_state(state_reg, S_IDLE), status_reg};
                `DRS_ADDR_ERR:  o_rdata <= {24'h0, o_err_code};
                `DRS_ADDR_FAIL: o_rdata <= {13'h0, cause_reg, tfail_reg};
                `DRS_ADDR_XFER: o_rdata <= {22'h0, outcome_reg, abort_cnt_reg};
                `DRS_ADDR_SAVES: o_rdata <= {16'h0, save_cnt_reg};
                default:        o_rdata <= 32'h0;
            endcase
        end
        else
            o_rdata <= 32'h0;
    end

    assign o_save_go           = is_state(state_reg, S_SAVE);
    assign o_restore_go        = is_state(state_reg, S_RESTORE);
    assign o_zero_go           = is_state(state_reg, S_ZERO);
    assign o_xfer_abort        = (is_state(state_reg, S_RESTORE) && i_ac_loss && !rest_end) ||
                                 (is_state(state_reg, S_SAVE) && !i_xfer_done &&
                                  (i_ac_return || (i_spin_up && restored_reg)));
    assign o_error_detect_bits = 2'h0; // [R2]
    assign o_forced_error_flag = 1'b0; // [R2]
    assign o_attn              = attn_pend_reg; // [R9]
    assign o_faulted           = fault_reg;
    assign o_host_access_ok    = !is_state(state_reg, S_TEST); // [R12]

endmodule

/* verilog/drs_map.vh */
`ifndef DRS_MAP_VH
`define DRS_MAP_VH

`define DRS_ST_NODATA   2'h0
`define DRS_ST_VALID    2'h1
`define DRS_ST_STALE    2'h2

`define DRS_ERR_NODATA  8'hE0
`define DRS_ERR_STALE   8'hE1

`define DRS_TEST_SEC    30
`define DRS_CLK_HZ      50000000
`define DRS_RESTORE_MIN_SEC 120
`define DRS_RESTORE_MAX_SEC 480

`define DRS_FAULT_REPORTS 3

`define DRS_ADDR_CTRL   4'h0
`define DRS_ADDR_STAT   4'h4
`define DRS_ADDR_ERR    4'h8
`define DRS_ADDR_FAIL   4'h1
`define DRS_ADDR_XFER   4'h2
`define DRS_ADDR_SAVES  4'h3

`define DRS_CTRL_ONLINE_BIT  0
`define DRS_STAT_ST_LSB      0
`define DRS_STAT_BUSY_BIT    2
`define DRS_STAT_RESTD_BIT   3
`define DRS_STAT_FAULT_BIT   4
`define DRS_STAT_SAVE_BIT    5
`define DRS_STAT_REST_BIT    6
`define DRS_STAT_ZERO_BIT    7

`endif

/* verilog/drs_tick.v */
`timescale 1ns/1ps
`include "drs_map.vh"

module drs_tick #(
    parameter CLK_HZ = `DRS_CLK_HZ
) (
    input  wire i_mclk,
    input  wire i_rst,
    output reg  o_sec
);

    localparam [31:0] LAST = CLK_HZ - 1;

    reg [31:0] cnt_reg;

    // One-cycle pulse once per second.
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_reg <= 32'h0;
            o_sec   <= 1'b0;
        end
        else if (cnt_reg == LAST)
        begin
            cnt_reg <= 32'h0;
            o_sec   <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
            o_sec   <= 1'b0;
        end
    end

endmodule

/* tb/drs_far_model.sv */
`timescale 1ns/1ps
module drs_far_model (
    input  wire  i_mclk,
    input  wire  i_rst,
    input  wire  i_go,
    output logic o_done
);
    logic [3:0] cnt;
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt    <= 4'h0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= i_go && cnt == 4'h1;
            if (!i_go)
                cnt <= 4'h3 + 4'($urandom % 8);
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

/* tb/drs_sequencer_assertions.sv */
`timescale 1ns/1ps
module drs_chk (
    input wire       i_mclk,
    input wire       i_rst,
    input wire       i_ac_loss,
    input wire       i_ac_return,
    input wire       i_spin_up,
    input wire       i_spin_down,
    input wire       i_op_fail,
    input wire       o_save_go,
    input wire       o_restore_go,
    input wire       o_zero_go,
    input wire [1:0] o_error_detect_bits,
    input wire       o_forced_error_flag,
    input wire [7:0] o_err_code,
    input wire       o_err_valid,
    input wire       o_faulted,
    input wire       o_host_access_ok
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    save_cause_a: assert property ($rose(o_save_go) |-> $past(i_spin_down || i_ac_loss))
        else $error("save began without cause");
    return_abort_a: assert property (o_save_go && i_ac_return |=> !o_save_go)
        else $error("save kept after mains return");
    spinup_abort_a: assert property (o_save_go && i_spin_up |=> !o_save_go)
        else $error("save kept after spin up");
    loss_abort_a: assert property (o_restore_go && i_ac_loss |=> !o_restore_go)
        else $error("restore kept after mains loss");
    early_spin_a: assert property (!o_host_access_ok && i_spin_down |=> !o_save_go)
        else $error("spin request acted on early");
    fault_set_a: assert property (i_op_fail |=> o_faulted)
        else $error("fault not latched");
    fault_hold_a: assert property (o_faulted |=> o_faulted)
        else $error("fault cleared");
    zero_word_a: assert property (o_error_detect_bits == 2'h0 && !o_forced_error_flag)
        else $error("zero word checks wrong");
    zero_code_a: assert property ($fell(o_zero_go) |-> ##[0:1] o_err_valid)
        else $error("no code after zero fill");
    access_kept_a: assert property (i_op_fail && o_host_access_ok |=> o_host_access_ok)
        else $error("host access lost on fault");
endmodule

/* tb/test_drs_sequencer.sv */
`timescale 1ns/1ps
module test_drs_sequencer;
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    logic [7:0]  ev     = 8'h00;
    logic [14:0] tf     = 15'h0000;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr   = 1'b0;
    logic        i_rd   = 1'b0;
    logic        rd_p   = 1'b0;
    wire         i_xfer_done;
    wire [31:0]  o_rdata;
    wire [7:0]   o_err_code;
    wire [1:0]   o_error_detect_bits;
    wire         o_save_go, o_restore_go, o_zero_go, o_xfer_abort, o_forced_error_flag;
    wire         o_err_valid, o_attn, o_faulted, o_host_access_ok;
    logic [63:0] q[$];
    int          miscompares = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          aborts = 0;
    always #10 i_mclk = ~i_mclk;
    drs_sequencer #(.CLK_HZ(10), .TEST_SEC(1), .RESTORE_MAX(20)) drs_sequencer_inst (
        .i_mclk, .i_rst, .i_ac_loss(ev[0]), .i_ac_return(ev[1]), .i_spin_up(ev[2]),
        .i_spin_down(ev[3]), .i_lbn_write(ev[4]), .i_online_ok(ev[7]), .i_test_fail(tf),
        .i_op_fail(ev[5]), .i_xfer_done, .i_xfer_fail(1'b0), .i_attn_ack(ev[6]), .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_save_go, .o_restore_go, .o_zero_go, .o_xfer_abort,
        .o_error_detect_bits, .o_forced_error_flag, .o_err_code, .o_err_valid, .o_attn,
        .o_faulted, .o_host_access_ok);
    drs_far_model drs_far_model_inst (.i_mclk, .i_rst,
        .i_go(o_save_go | o_restore_go | o_zero_go), .o_done(i_xfer_done));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task pl(input int b);
        @(posedge i_mclk) ev[b] <= 1'b1;
        @(posedge i_mclk) ev <= 8'h00;
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk) i_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        q.push_back({m, e});
        @(posedge i_mclk) i_rd <= 1'b0;
        @(posedge i_mclk);
        #1;
    endtask
    always @(posedge i_mclk)
    begin
        if (rd_p || o_err_valid)
        begin
            logic [63:0] n;
            n = q.pop_front();
            chk("result", (rd_p ? o_rdata : {24'h0, o_err_code}) & n[63:32], n[31:0]);
        end
        if (o_xfer_abort)
            aborts++;
        rd_p <= i_rd;
        if (++cyc > 4000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end
    task powerup;
        q.push_back({32'hFFFFFFFF, 32'hE0});
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        pl(3);
        chk("early_save", o_save_go, 0);
        wait (o_zero_go === 1'b1);
        wait (o_zero_go === 1'b0);
        repeat (3) @(posedge i_mclk);
        #1;
    endtask
    initial
    begin
        void'($urandom(29838));
        powerup;
        $display("powerup zero fill done");
        rd(4'h8, 32'hFF, 32'hE0);
        wr(4'hC, $urandom);
        rd(4'hC, 32'hFFFFFFFF, 32'h0);
        pl(3);
        chk("save_go", o_save_go, 1);
        wait (o_save_go === 1'b0);
        rd(4'h4, 32'h13, 32'h1);
        pl(3);
        chk("save_go", o_save_go, 0);
        pl(4);
        rd(4'h4, 32'h3, 32'h2);
        $display("spin down save done");
        pl(0);
        chk("save_go", o_save_go, 1);
        pl(1);
        chk("save_go", o_save_go, 0);
        rd(4'h4, 32'h3, 32'h0);
        pl(3);
        pl(2);
        chk("save_go", o_save_go, 0);
        rd(4'h4, 32'h3, 32'h0);
        pl(0);
        wait (o_save_go === 1'b0);
        pl(1);
        chk("restore_go", o_restore_go, 0);
        rd(4'h4, 32'h3, 32'h1);
        rd(4'h3, 32'hFFFF, 32'h2);
        chk("aborts", aborts, 2);
        $display("mains events done");
        wr(4'h0, 32'h1);
        pl(5);
        chk("faulted", {o_faulted, o_attn, o_host_access_ok}, 3'h7);
        repeat (3) pl(6);
        repeat (2) @(posedge i_mclk);
        #1;
        chk("attn", {o_faulted, o_attn}, 2'h2);
        pl(7);
        chk("attn", o_attn, 1);
        repeat (3) pl(6);
        chk("attn", o_attn, 0);
        powerup;
        chk("faulted", o_faulted, 0);
        @(posedge i_mclk) tf <= 15'($urandom) | 15'h0001;
        powerup;
        chk("faulted", {o_faulted, o_host_access_ok}, 2'h3);
        $display("fault handling done");
        tally_and_finish;
    end
endmodule
bind drs_sequencer drs_chk drs_chk_inst (.i_mclk, .i_rst, .i_ac_loss, .i_ac_return,
    .i_spin_up, .i_spin_down, .i_op_fail, .o_save_go, .o_restore_go, .o_zero_go,
    .o_error_detect_bits, .o_forced_error_flag, .o_err_code, .o_err_valid, .o_faulted,
    .o_host_access_ok);
